// [oep_pkg.sv]
// Constants and types shared by the offset/expand output path.
package oep_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD  = 8'h04;
   localparam logic [7:0] A_XOFF = 8'h08;
   localparam logic [7:0] A_YOFF = 8'h0c;
   localparam logic [7:0] A_ROFF = 8'h10;
   localparam logic [7:0] A_ROT  = 8'h14;
   localparam logic [7:0] A_EXP  = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1c;
   localparam logic [7:0] A_DATA = 8'h20;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_DISP = 0;
   localparam int CTRL_OSEL = 2;
   localparam int CTRL_XYEN = 3;
   localparam int CTRL_REN  = 4;
   localparam int CTRL_SENS = 5;
   localparam int CMD_AUTO  = 0;
   localparam int CMD_EXP   = 1;
   localparam int CMD_OFFT  = 2;
   localparam int EXP_X     = 0;
   localparam int EXP_Y     = 2;
   localparam int EXP_R     = 4;
   localparam int ROT_SIN   = 16;
   localparam int ST_RDBK   = 16;
   // ------------------------------------------------------------
   // Arithmetic constants
   // ------------------------------------------------------------
   localparam int Q_BITS = 15;
   localparam int R_BITS = 14;
   localparam logic [3:0] SENS_RST = 4'hf;
   localparam logic signed [47:0] GAIN10  = 48'sd10;
   localparam logic signed [47:0] GAIN100 = 48'sd100;
   // Full scale is 2**Q_BITS; the clamp sits at 110 % of it.
   localparam logic signed [47:0] LIM = 48'sd36044;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {OEP_DX, OEP_DY, OEP_DR} oep_disp_t;
   typedef enum logic [1:0] {OEP_E1, OEP_E10, OEP_E100} oep_exp_t;
   typedef struct packed {
      logic signed [15:0] y;
      logic signed [15:0] x;
   } oep_sample_t;
   typedef struct packed {
      logic               ovl;
      logic signed [17:0] v;
   } oep_chan_t;
endpackage

// [oep_top.sv]
// Offset, rotation, expand and clamp path for one output channel.
//
// Added by the designer: the register offsets and the APB register port.

// ---------------------------------------------------------------
// Sample FIFO
// ---------------------------------------------------------------
module oep_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Fill side
   input  wire logic         s_valid,
   output logic              s_ready,
   input  wire logic [W-1:0] s_data,
   // Drain side
   output logic              m_valid,
   input  wire logic         m_ready,
   output logic [W-1:0]      m_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;
   logic [AW:0]   next_cnt;
   logic          push;
   logic          pop;

   assign push = s_valid && s_ready;
   assign pop = m_valid && m_ready;
   assign m_data = mem[rp];
   assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wp] <= s_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         s_ready <= 1'b0;
         m_valid <= 1'b0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
         end
         cnt <= next_cnt;
         // Full and empty are registered so s_ready and m_valid are flop outputs.
         s_ready <= next_cnt != (AW+1)'(D);
         m_valid <= next_cnt != '0;
      end
   end
endmodule

// ---------------------------------------------------------------
// Output path
// ---------------------------------------------------------------
module oep_top #(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Demodulator samples
   input  wire logic                in_valid,
   output logic                     in_ready,
   input  wire oep_pkg::oep_sample_t in_data,
   // Display and analog output
   output logic                     out_valid,
   input  wire logic                out_ready,
   output logic signed [17:0]       disp_value,
   output logic signed [17:0]       aout_value,
   // Indicators
   output logic                     overload_flag,
   output logic                     disp_overload_flag,
   output logic                     paired_offset_flag,
   output logic                     magnitude_offset_flag,
   output logic                     expand_flag
);
   oep_pkg::oep_disp_t  disp;
   oep_pkg::oep_exp_t   x_exp;
   oep_pkg::oep_exp_t   y_exp;
   oep_pkg::oep_exp_t   r_exp;
   oep_pkg::oep_sample_t f_data;
   oep_pkg::oep_chan_t  ch_x;
   oep_pkg::oep_chan_t  ch_d;
   logic                out_x;
   logic                xy_en;
   logic                r_en;
   logic [3:0]          sens;
   logic signed [15:0]  x_off;
   logic signed [15:0]  y_off;
   logic signed [15:0]  r_off;
   logic signed [15:0]  lx;
   logic signed [15:0]  ly;
   logic signed [17:0]  cx;
   logic signed [17:0]  cy;
   logic signed [17:0]  cr;
   logic signed [17:0]  lr;
   logic signed [15:0]  rd_off;
   logic signed [31:0]  rx;
   logic signed [31:0]  ry;
   logic                f_valid;
   logic                pop;
   logic                wr;
   logic                setup;
   logic [31:0]         rdv;
   logic                hit;

   // ------------------------------------------------------------
   // Channel arithmetic
   // ------------------------------------------------------------
   function automatic oep_pkg::oep_chan_t chan(
      input logic signed [17:0] q,
      input logic signed [15:0] off,
      input logic               en,
      input oep_pkg::oep_exp_t  ex,
      input logic [3:0]         sh
   );
      logic signed [47:0] a;
      logic signed [47:0] n;
      logic signed [47:0] p;
      oep_pkg::oep_chan_t r;
      a = en ? ((48'(off) <<< sh) >>> oep_pkg::Q_BITS) : '0;
      n = (48'(q) - a) <<< (oep_pkg::Q_BITS - int'(sh));
      case (ex)
         oep_pkg::OEP_E10:  p = n * oep_pkg::GAIN10;
         oep_pkg::OEP_E100: p = n * oep_pkg::GAIN100;
         default:           p = n;
      endcase
      r.ovl = (p > oep_pkg::LIM) || (p < -oep_pkg::LIM);
      if (r.ovl) begin
         r.v = (p > 0) ? 18'(oep_pkg::LIM) : 18'(-oep_pkg::LIM);
      end else begin
         r.v = 18'(p);
      end
      return r;
   endfunction

   // Alpha-max beta-min estimate: max + 3/8 min, within a few percent.
   function automatic logic signed [17:0] mag(
      input logic signed [17:0] a,
      input logic signed [17:0] b
   );
      logic [17:0] ua;
      logic [17:0] ub;
      logic [17:0] hi;
      logic [17:0] lo;
      ua = a[17] ? 18'(-a) : 18'(a);
      ub = b[17] ? 18'(-b) : 18'(b);
      hi = (ua > ub) ? ua : ub;
      lo = (ua > ub) ? ub : ua;
      return 18'(hi + (lo >> 2) + (lo >> 3));
   endfunction

   oep_fifo #(.W($bits(oep_pkg::oep_sample_t)), .D(DEPTH)) u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .s_valid (in_valid),
      .s_ready (in_ready),
      .s_data  (in_data),
      .m_valid (f_valid),
      .m_ready (pop),
      .m_data  (f_data)
   );

   assign pop = f_valid && (!out_valid || out_ready);
   // Offset vector in raw sample units; magnitude from corrected X/Y.
   assign cx = 18'(f_data.x) - 18'(xy_en ? x_off >>> (oep_pkg::Q_BITS
               - int'(sens)) : 16'sh0);
   assign cy = 18'(f_data.y) - 18'(xy_en ? y_off >>> (oep_pkg::Q_BITS
               - int'(sens)) : 16'sh0);
   assign cr = mag(cx, cy);
   // X and Y carry no second offset: it is already in cx, cy.
   assign ch_x = chan(cx, x_off, 1'b0, x_exp, sens);
   always_comb begin
      case (disp)
         oep_pkg::OEP_DY: ch_d = chan(cy, y_off, 1'b0, y_exp, sens);
         oep_pkg::OEP_DR: ch_d = chan(cr, r_off, r_en, r_exp, sens);
         default:         ch_d = ch_x;
      endcase
   end

   // ------------------------------------------------------------
   // Sample update
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         disp_value <= '0;
         aout_value <= '0;
         overload_flag <= 1'b0;
         disp_overload_flag <= 1'b0;
         lx <= '0;
         ly <= '0;
      end else begin
         if (out_ready) begin
            out_valid <= 1'b0;
         end
         if (pop) begin
            out_valid <= 1'b1;
            lx <= f_data.x;
            ly <= f_data.y;
            disp_value <= ch_d.v;
            aout_value <= out_x ? ch_x.v : ch_d.v;
            overload_flag <= out_x ? ch_x.ovl : ch_d.ovl;
            disp_overload_flag <= ch_d.ovl;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         paired_offset_flag <= 1'b0;
         magnitude_offset_flag <= 1'b0;
         expand_flag <= 1'b0;
      end else begin
         paired_offset_flag <= xy_en;
         magnitude_offset_flag <= r_en && disp == oep_pkg::OEP_DR;
         case (disp)
            oep_pkg::OEP_DY: expand_flag <= y_exp != oep_pkg::OEP_E1;
            oep_pkg::OEP_DR: expand_flag <= r_exp != oep_pkg::OEP_E1;
            default:         expand_flag <= x_exp != oep_pkg::OEP_E1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // APB slave, one wait-free access per transfer
   // ------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;
   assign lr = mag(18'(lx) - 18'(xy_en ? x_off >>> (oep_pkg::Q_BITS
               - int'(sens)) : 16'sh0), 18'(ly) - 18'(xy_en ? y_off
               >>> (oep_pkg::Q_BITS - int'(sens)) : 16'sh0));
   assign rx = x_off * 32'(ld_cos()) + y_off * 32'(ld_sin());
   assign ry = y_off * 32'(ld_cos()) - x_off * 32'(ld_sin());
   assign rd_off = (disp == oep_pkg::OEP_DR) ? r_off :
                   (disp == oep_pkg::OEP_DY) ? y_off : x_off;

   function automatic logic signed [15:0] ld_cos();
      return pwdata[15:0];
   endfunction

   function automatic logic signed [15:0] ld_sin();
      return pwdata[31:oep_pkg::ROT_SIN];
   endfunction

   always_comb begin
      hit = 1'b1;
      rdv = '0;
      case (paddr)
         oep_pkg::A_CTRL: rdv = 32'({sens, r_en, xy_en, out_x, disp});
         oep_pkg::A_CMD:  rdv = '0;
         oep_pkg::A_XOFF: rdv = 32'(x_off);
         oep_pkg::A_YOFF: rdv = 32'(y_off);
         oep_pkg::A_ROFF: rdv = 32'(r_off);
         oep_pkg::A_ROT:  rdv = '0;
         oep_pkg::A_EXP:  rdv = 32'({r_exp, y_exp, x_exp});
         oep_pkg::A_STAT: rdv = {rd_off, 11'h0, expand_flag,
                                 magnitude_offset_flag, paired_offset_flag,
                                 disp_overload_flag, overload_flag};
         oep_pkg::A_DATA: rdv = 32'(aout_value);
         default:         hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite) ? rdv : '0;
      end
   end

   // ------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp <= oep_pkg::OEP_DX;
         out_x <= 1'b1;
         xy_en <= 1'b0;
         r_en <= 1'b0;
         sens <= oep_pkg::SENS_RST;
      end else if (wr && paddr == oep_pkg::A_CTRL) begin
         disp <= oep_pkg::oep_disp_t'(pwdata[oep_pkg::CTRL_DISP +: 2]);
         out_x <= pwdata[oep_pkg::CTRL_OSEL];
         xy_en <= pwdata[oep_pkg::CTRL_XYEN];
         r_en <= pwdata[oep_pkg::CTRL_REN];
         sens <= pwdata[oep_pkg::CTRL_SENS +: 4];
      end else if (wr && paddr == oep_pkg::A_CMD) begin
         if (pwdata[oep_pkg::CMD_OFFT]) begin
            if (disp == oep_pkg::OEP_DR) begin
               r_en <= !r_en;
            end else begin
               xy_en <= !xy_en;
            end
         end
         // Loaded values only cancel the input once they are switched on.
         if (pwdata[oep_pkg::CMD_AUTO]) begin
            if (disp == oep_pkg::OEP_DR) begin
               r_en <= 1'b1;
            end else begin
               xy_en <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_off <= '0;
         y_off <= '0;
         r_off <= '0;
      end else if (wr) begin
         case (paddr)
            oep_pkg::A_XOFF: x_off <= pwdata[15:0];
            oep_pkg::A_YOFF: y_off <= pwdata[15:0];
            oep_pkg::A_ROFF: r_off <= pwdata[15:0];
            oep_pkg::A_ROT: begin
               x_off <= 16'(rx >>> oep_pkg::R_BITS);
               y_off <= 16'(ry >>> oep_pkg::R_BITS);
            end
            oep_pkg::A_CMD: begin
               if (pwdata[oep_pkg::CMD_AUTO]) begin
                  if (disp == oep_pkg::OEP_DR) begin
                     r_off <= 16'(48'(lr) <<< (oep_pkg::Q_BITS
                              - int'(sens)));
                  end else begin
                     x_off <= 16'(32'(lx) <<< (oep_pkg::Q_BITS
                              - int'(sens)));
                     y_off <= 16'(32'(ly) <<< (oep_pkg::Q_BITS
                              - int'(sens)));
                  end
               end
            end
            default: ;
         endcase
      end
   end

   function automatic oep_pkg::oep_exp_t step(input oep_pkg::oep_exp_t e);
      case (e)
         oep_pkg::OEP_E1:  return oep_pkg::OEP_E10;
         oep_pkg::OEP_E10: return oep_pkg::OEP_E100;
         default:          return oep_pkg::OEP_E1;
      endcase
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_exp <= oep_pkg::OEP_E1;
         y_exp <= oep_pkg::OEP_E1;
         r_exp <= oep_pkg::OEP_E1;
      end else if (wr && paddr == oep_pkg::A_EXP) begin
         x_exp <= oep_pkg::oep_exp_t'(pwdata[oep_pkg::EXP_X +: 2]);
         y_exp <= oep_pkg::oep_exp_t'(pwdata[oep_pkg::EXP_Y +: 2]);
         r_exp <= oep_pkg::oep_exp_t'(pwdata[oep_pkg::EXP_R +: 2]);
      end else if (wr && paddr == oep_pkg::A_CMD
                   && pwdata[oep_pkg::CMD_EXP]) begin
         case (disp)
            oep_pkg::OEP_DY: y_exp <= step(y_exp);
            oep_pkg::OEP_DR: r_exp <= step(r_exp);
            default:         x_exp <= step(x_exp);
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence cmd_wr(int b);
      wr && paddr == oep_pkg::A_CMD && pwdata[b];
   endsequence

   exp_cycle_a: assert property (cmd_wr(oep_pkg::CMD_EXP)
      and disp == oep_pkg::OEP_DX and x_exp == oep_pkg::OEP_E100
      |=> x_exp == oep_pkg::OEP_E1) else $error("expand did not wrap");
   clamp_lim_a: assert property (out_valid && !overload_flag
      |-> aout_value <= 18'(oep_pkg::LIM)
      && aout_value >= 18'(-oep_pkg::LIM))
      else $error("output beyond clamp");
   ovl_at_lim_a: assert property (overload_flag
      |-> aout_value == 18'(oep_pkg::LIM)
      || aout_value == 18'(-oep_pkg::LIM))
      else $error("overload without clamp");
   mag_flag_a: assert property (r_en && disp == oep_pkg::OEP_DR
      ##1 r_en && disp == oep_pkg::OEP_DR |-> magnitude_offset_flag)
      else $error("magnitude offset flag missing");
   expand_flag_a: assert property ($rose(expand_flag)
      |-> $past(x_exp != oep_pkg::OEP_E1 || y_exp != oep_pkg::OEP_E1
      || r_exp != oep_pkg::OEP_E1)) else $error("expand flag wrong");
   auto_pair_a: assert property (cmd_wr(oep_pkg::CMD_AUTO)
      and disp == oep_pkg::OEP_DY and sens == oep_pkg::SENS_RST
      |=> x_off == $past(lx) && y_off == $past(ly))
      else $error("auto offset not paired");
   rot_zero_a: assert property (wr && paddr == oep_pkg::A_ROT
      && pwdata == 32'h00004000 |=> $stable(x_off) && $stable(y_off))
      else $error("unit rotation changed offsets");
   r_isolate_a: assert property (wr && paddr == oep_pkg::A_ROFF
      |=> $stable(x_off) && $stable(y_off) && $stable(x_exp))
      else $error("magnitude offset touched X or Y");
   apb_ready_a: assert property (psel && !penable
      |=> pready ##1 !pready) else $error("APB answer timing");
endmodule

// [oep_demod_model.sv]
// Behavioural demodulator that feeds X/Y samples to the output path.
module oep_demod_model (
   // Clock
   input  wire logic            pclk,
   // Sample stream
   output logic                 in_valid,
   input  wire logic            in_ready,
   output oep_pkg::oep_sample_t in_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      in_valid = 1'h0;
      in_data  = 32'h0;
   end

   // A sample is held until taken or 40 cycles pass; after release the data bus shows the
   // inverse of the last word so a late reader cannot see a stale match.
   task automatic send(input logic [15:0] x, input logic [15:0] y,
                       output logic ok);
      int k;
      @(posedge pclk);
      in_valid <= 1'h1;
      in_data  <= {y, x};
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (in_ready !== 1'h1 && k < 40);
      ok = (in_ready === 1'h1);
      in_valid <= 1'h0;
      in_data  <= ~{y, x};
   endtask
endmodule

// [offset_expand_output_path_bench.sv]
// Self-checking bench for the offset/expand output path.
module offset_expand_output_path_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Signals
   // ----------
   logic                 pclk = 1'h0;
   logic                 presetn = 1'h0;
   logic                 psel = 1'h0;
   logic                 penable = 1'h0;
   logic                 pwrite = 1'h0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 in_valid;
   logic                 in_ready;
   oep_pkg::oep_sample_t in_data;
   logic                 out_valid;
   logic                 out_ready = 1'h0;
   logic signed [17:0]   disp_value;
   logic signed [17:0]   aout_value;
   wire  [4:0]           flg;
   logic [31:0]          rd;
   logic                 er;
   logic                 ok;
   int                   err_count = 0;
   int                   compares = 0;
   int                   n;

   initial forever #4 pclk = ~pclk;

   oep_top #(.DEPTH(16)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
      .out_ready(out_ready), .disp_value(disp_value),
      .aout_value(aout_value), .overload_flag(flg[4]),
      .disp_overload_flag(flg[3]), .paired_offset_flag(flg[2]),
      .magnitude_offset_flag(flg[1]), .expand_flag(flg[0]));

   oep_demod_model demod (
      .pclk(pclk), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data));

   // ----------
   // Tasks
   // ----------
   task automatic wrap_up();
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic hang();
      err_count++;
      wrap_up();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   // The request stays put until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k >= 20) hang();
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd & m, e);
   endtask

   // Results are looked at mid-cycle, then taken with a one-cycle ready.
   task automatic get(input int d, input int a, input logic [4:0] f);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (out_valid !== 1'h1 && k < 60);
      if (k >= 60) hang();
      chk(32'(disp_value), 32'(d));
      chk(32'(aout_value), 32'(a));
      chk({27'h0, flg}, {27'h0, f});
      @(posedge pclk);
      out_ready <= 1'h1;
      @(posedge pclk);
      out_ready <= 1'h0;
   endtask

   task automatic smp(input int x, input int y, input int d, input int a,
                      input logic [4:0] f);
      demod.send(16'(x), 16'(y), ok);
      get(d, a, f);
   endtask

   // ----------
   // Sequence
   // ----------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rc(oep_pkg::A_CTRL, 32'hffffffff, 32'h000001e4);
      rc(oep_pkg::A_STAT, 32'hffffffff, 32'h00000000);
      rc(8'h40, 32'hffffffff, 32'h0);
      chk({31'h0, er}, 32'h1);
      // Fill until refused with the sink stalled, then drain in order.
      n = 0;
      do begin
         demod.send(16'(n + 1), 16'h0, ok);
         if (ok === 1'h1) n++;
      end while (ok === 1'h1 && n < 24);
      chk(32'(n >= 16 && n <= 19), 32'h1);
      chk({31'h0, in_ready}, 32'h0);
      for (int i = 1; i <= n; i++) get(i, i, 5'h00);
      smp(1000, -400, 1000, 1000, 5'h00);
      apb(1'h1, oep_pkg::A_CMD, 32'h1);
      rc(oep_pkg::A_XOFF, 32'hffff, 32'h03e8);
      rc(oep_pkg::A_YOFF, 32'hffff, 32'hfe70);
      rc(oep_pkg::A_CTRL, 32'hffffffff, 32'h1ec);
      smp(1500, -400, 500, 500, 5'h04);
      rc(oep_pkg::A_STAT, 32'hffffffff, 32'h03e80004);
      apb(1'h1, oep_pkg::A_CMD, 32'h2);
      smp(1500, -400, 5000, 5000, 5'h05);
      apb(1'h1, oep_pkg::A_CMD, 32'h2);
      smp(1500, -400, 36044, 36044, 5'h1d);
      apb(1'h1, oep_pkg::A_CMD, 32'h2);
      rc(oep_pkg::A_EXP, 32'hffffffff, 32'h0);
      apb(1'h1, oep_pkg::A_EXP, 32'h1);
      apb(1'h1, oep_pkg::A_CTRL, 32'h1ea);
      smp(1500, -400, 500, 500, 5'h04);
      apb(1'h1, oep_pkg::A_CTRL, 32'h1ee);
      smp(1500, -400, 500, 5000, 5'h04);
      apb(1'h1, oep_pkg::A_ROFF, 32'h00c8);
      apb(1'h1, oep_pkg::A_CMD, 32'h6);
      smp(1500, -400, 3000, 5000, 5'h07);
      rc(oep_pkg::A_EXP, 32'hffffffff, 32'h11);
      apb(1'h1, oep_pkg::A_CTRL, 32'h1ec);
      apb(1'h1, oep_pkg::A_ROT, 32'h40000000);
      apb(1'h1, oep_pkg::A_ROT, 32'h00004000);
      rc(oep_pkg::A_XOFF, 32'hffff, 32'hfe70);
      rc(oep_pkg::A_YOFF, 32'hffff, 32'hfc18);
      smp(1500, -400, 19000, 19000, 5'h05);
      apb(1'h1, oep_pkg::A_CMD, 32'h4);
      rc(oep_pkg::A_CTRL, 32'hffffffff, 32'h1e4);
      smp(1500, 0, 15000, 15000, 5'h01);
      apb(1'h1, oep_pkg::A_CTRL, 32'h1cc);
      rc(oep_pkg::A_XOFF, 32'hffff, 32'hfe70);
      smp(100, 0, 6000, 6000, 5'h05);
      apb(1'h1, oep_pkg::A_CTRL, 32'h1ed);
      smp(100, -900, 100, 5000, 5'h04);
      apb(1'h1, oep_pkg::A_CMD, 32'h1);
      rc(oep_pkg::A_XOFF, 32'hffff, 32'h0064);
      rc(oep_pkg::A_YOFF, 32'hffff, 32'hfc7c);
      rc(oep_pkg::A_STAT, 32'hffff0000, 32'hfc7c0000);
      smp(100, -900, 0, 0, 5'h04);
      wrap_up();
   end
endmodule
